// ### logic/smic_top.sv
/*
 * smic_top: synchronous memory interface controller (burst sram, zbt sram,
 * synchronous fifo) with per-space settings and a plain register port.
 * assumes: ref_clk_i at 10 MHz; link_clk_i free-running; memory pins
 * timed by the chosen output clock.
 */
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module smic_top
    import smic_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [smic_pkg::SMIC_RAW-1:0] reg_addr_i,
    input wire logic [smic_pkg::SMIC_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [smic_pkg::SMIC_DW-1:0] reg_rdata_o,
    input wire logic link_clk_i,
    output logic ext_clock_out_one_o,
    output logic ext_clock_out_two_o,
    output logic [smic_pkg::SMIC_SPACES-1:0] space_chip_enable_n_o,
    output logic shared_read_strobe_pin_o,
    output logic shared_output_enable_pin_o,
    output logic shared_write_strobe_pin_o,
    output logic [smic_pkg::SMIC_AW-1:0] mem_addr_o,
    input wire logic [smic_pkg::SMIC_DW-1:0] mem_data_i,
    output logic [smic_pkg::SMIC_DW-1:0] mem_data_o,
    output logic mem_data_oe_o
);
    import smic_pkg::*;

    function automatic smic_sec_t to_sec(input logic [SMIC_DW-1:0] w);
        smic_sec_t s;
        s.sync_read_latency = w[SEC_RL_LSB +: 2];
        s.sync_write_latency = w[SEC_WL_LSB +: 2];
        s.chip_enable_extend = w[SEC_CHIP_ENABLE_EXTEND_BIT];
        s.strobe_as_read_enable = w[SEC_RDEN_BIT];
        s.sync_clock_select = w[SEC_CLKSEL_BIT];
        return s;
    endfunction

    function automatic logic [SMIC_DW-1:0] from_sec(input smic_sec_t s);
        logic [SMIC_DW-1:0] w;
        w = '0;
        w[SEC_RL_LSB +: 2] = s.sync_read_latency;
        w[SEC_WL_LSB +: 2] = s.sync_write_latency;
        w[SEC_CHIP_ENABLE_EXTEND_BIT] = s.chip_enable_extend;
        w[SEC_RDEN_BIT] = s.strobe_as_read_enable;
        w[SEC_CLKSEL_BIT] = s.sync_clock_select;
        return w;
    endfunction

    // block of four words starting at base
    function automatic logic in_block(input logic [SMIC_RAW-1:0] a,
                                      input logic [SMIC_RAW-1:0] base);
        return a[SMIC_RAW-1:4] == base[SMIC_RAW-1:4];
    endfunction

    // ------------------------------------------------------------
    // register port (ref_clk_i domain)
    // ------------------------------------------------------------
    smic_sec_t sec_q [SMIC_SPACES];
    logic [SMIC_AW-1:0] addr_q;
    logic [SMIC_DW-1:0] wdat_q [SMIC_WORDS];
    logic [SMIC_DW-1:0] rdat_q [SMIC_WORDS];
    smic_cmd_t cmd_q;
    logic req_tgl_q;
    logic ack_seen_q;
    logic busy_q;
    logic [SMIC_DW-1:0] rdata_q;
    logic ack_sync;
    logic [SMIC_DW-1:0] link_mem [SMIC_WORDS];

    wire [1:0] widx = reg_addr_i[3:2];
    wire hit_sec = in_block(reg_addr_i, SMIC_OFS_SEC_BASE);
    wire hit_wdat = in_block(reg_addr_i, SMIC_OFS_WDAT_BASE);
    wire hit_rdat = in_block(reg_addr_i, SMIC_OFS_RDAT_BASE);
    wire hit_addr = reg_addr_i == SMIC_OFS_ADDR;
    wire hit_cmd = reg_addr_i == SMIC_OFS_CMD;
    wire hit_stat = reg_addr_i == SMIC_OFS_STATUS;
    wire start = reg_wr_i && hit_cmd && !busy_q;
    wire ack_seen = ack_sync != ack_seen_q;
    wire [1:0] start_space = reg_wdata_i[CMD_SPACE_LSB +: 2];

    logic [SMIC_DW-1:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        if (hit_sec)
            rd_mux = from_sec(sec_q[widx]);
        else if (hit_wdat)
            rd_mux = wdat_q[widx];
        else if (hit_rdat)
            rd_mux = rdat_q[widx];
        else if (hit_addr)
            rd_mux = {{(SMIC_DW-SMIC_AW){1'b0}}, addr_q};
        else if (hit_cmd)
        begin
            rd_mux[CMD_WRITE_BIT] = cmd_q.write;
            rd_mux[CMD_SPACE_LSB +: 2] = cmd_q.space;
            rd_mux[CMD_LEN_LSB +: 2] = cmd_q.len_m1;
        end
        else if (hit_stat)
            rd_mux[STAT_BUSY_BIT] = busy_q;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < SMIC_SPACES; i++)
                sec_q[i] <= SMIC_SEC_RST;
            addr_q <= '0;
            rdata_q <= '0;
        end
        else
        begin
            if (reg_wr_i && hit_sec)
                sec_q[widx] <= to_sec(reg_wdata_i);
            if (reg_wr_i && hit_addr)
                addr_q <= reg_wdata_i[SMIC_AW-1:0];
            if (reg_rd_i)
                rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            for (int i = 0; i < SMIC_WORDS; i++)
            begin
                wdat_q[i] <= '0;
                rdat_q[i] <= '0;
            end
        end
        else
        begin
            if (reg_wr_i && hit_wdat && !busy_q)
                wdat_q[widx] <= reg_wdata_i;
            if (ack_seen && !cmd_q.write)
                for (int i = 0; i < SMIC_WORDS; i++)
                    rdat_q[i] <= link_mem[i];
        end
    end

    // command snapshot and toggle handshake towards the link side
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            cmd_q <= '0;
            req_tgl_q <= 1'b0;
            ack_seen_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            if (start)
            begin
                cmd_q.sec <= sec_q[start_space];
                cmd_q.write <= reg_wdata_i[CMD_WRITE_BIT];
                cmd_q.space <= start_space;
                cmd_q.len_m1 <= reg_wdata_i[CMD_LEN_LSB +: 2];
                cmd_q.addr <= addr_q;
                req_tgl_q <= ~req_tgl_q;
                busy_q <= 1'b1;
            end
            else if (ack_seen)
                busy_q <= 1'b0;
            if (ack_seen)
                ack_seen_q <= ack_sync;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------
    // link side (link_clk_i domain)
    // ------------------------------------------------------------
    logic link_rst_n;
    logic req_sync;
    smic_lstate_t ls_q;
    logic req_seen_q;
    logic ack_tgl_q;
    logic div_q;
    logic [2:0] cmd_cnt_q;
    logic [2:0] beat_q;
    logic [2:0] pipe_q;
    logic cmd_on_q;
    smic_pins_t pins_q;

    smic_sync u_rst_sync
    (
        .clk_i(link_clk_i),
        .rst_n_i(1'b1),
        .d_i(reset_n_i),
        .q_o(link_rst_n)
    );

    smic_sync u_req_sync
    (
        .clk_i(link_clk_i),
        .rst_n_i(link_rst_n),
        .d_i(req_tgl_q),
        .q_o(req_sync)
    );

    smic_sync u_ack_sync
    (
        .clk_i(ref_clk_i),
        .rst_n_i(reset_n_i),
        .d_i(ack_tgl_q),
        .q_o(ack_sync)
    );

    // second output clock is the link clock halved
    always_ff @(posedge link_clk_i)
    begin
        if (!link_rst_n)
            div_q <= 1'b0;
        else
            div_q <= ~div_q;
    end

    // memory-side state advances only on rising edges of the chosen clock
    wire step = !cmd_q.sec.sync_clock_select || !div_q;
    wire [2:0] len = {1'b0, cmd_q.len_m1} + 3'd1;
    wire is_rd = !cmd_q.write;
    wire [3:0] taps = {pipe_q, cmd_on_q};
    wire issue = ls_q == LS_CMD;
    wire [3:0] taps_nx = {pipe_q[1:0], cmd_on_q, issue};
    wire rd_hit = is_rd && taps[cmd_q.sec.sync_read_latency];
    wire wr_hit = !is_rd && taps_nx[cmd_q.sec.sync_write_latency];
    wire [2:0] beat_nx = beat_q + {2'b00, rd_hit || wr_hit};
    wire drain_done = (ls_q == LS_DRAIN) && (beat_nx == len);
    wire desel = drain_done && !cmd_q.sec.strobe_as_read_enable;
    wire oe_nx = is_rd && (issue || ((ls_q == LS_DRAIN) && !drain_done));
    wire ce_nx = issue || (cmd_q.sec.chip_enable_extend && oe_nx);
    wire strobe_nx = cmd_q.sec.strobe_as_read_enable ?
                     (issue && is_rd) : (issue || desel);
    wire [SMIC_AW-1:0] cmd_addr = cmd_q.addr + {{(SMIC_AW-3){1'b0}}, cmd_cnt_q};

    smic_pins_t pins_d;
    always_comb
    begin
        pins_d = pins_q;
        pins_d.space_chip_enable_n = '1;
        pins_d.space_chip_enable_n[cmd_q.space] = !ce_nx;
        pins_d.sync_addr_strobe_or_read_enable = !strobe_nx;
        pins_d.sync_output_enable_n = !oe_nx;
        pins_d.sync_write_enable_n = !(issue && !is_rd);
        if (issue)
            pins_d.addr = cmd_addr;
        pins_d.dout_oe = wr_hit;
        if (wr_hit)
            pins_d.dout = wdat_q[beat_q[1:0]];
    end

    always_ff @(posedge link_clk_i)
    begin
        if (!link_rst_n)
        begin
            ls_q <= LS_IDLE;
            req_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
            cmd_cnt_q <= '0;
            beat_q <= '0;
            pipe_q <= '0;
            cmd_on_q <= 1'b0;
            pins_q <= SMIC_PINS_RST;
        end
        else if (step)
        begin
            pins_q <= pins_d;
            cmd_on_q <= issue;
            pipe_q <= taps[2:0];
            beat_q <= beat_nx;
            case (ls_q)
                LS_IDLE:
                begin
                    beat_q <= '0;
                    cmd_cnt_q <= '0;
                    if (req_sync != req_seen_q)
                    begin
                        req_seen_q <= req_sync;
                        ls_q <= LS_CMD;
                    end
                end
                LS_CMD:
                begin
                    cmd_cnt_q <= cmd_cnt_q + 3'd1;
                    if (cmd_cnt_q + 3'd1 == len)
                        ls_q <= LS_DRAIN;
                end
                LS_DRAIN:
                begin
                    if (drain_done)
                        ls_q <= LS_DONE;
                end
                LS_DONE:
                begin
                    ack_tgl_q <= ~ack_tgl_q;
                    ls_q <= LS_IDLE;
                end
                default:
                    ls_q <= LS_IDLE;
            endcase
        end
    end

    // read data capture at the programmed latency
    always_ff @(posedge link_clk_i)
    begin
        if (!link_rst_n)
        begin
            for (int i = 0; i < SMIC_WORDS; i++)
                link_mem[i] <= '0;
        end
        else if (step && rd_hit)
            link_mem[beat_q[1:0]] <= mem_data_i;
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    assign ext_clock_out_one_o = link_clk_i;
    assign ext_clock_out_two_o = div_q;
    assign space_chip_enable_n_o = pins_q.space_chip_enable_n;
    assign shared_read_strobe_pin_o = pins_q.sync_addr_strobe_or_read_enable;
    assign shared_output_enable_pin_o = pins_q.sync_output_enable_n;
    assign shared_write_strobe_pin_o = pins_q.sync_write_enable_n;
    assign mem_addr_o = pins_q.addr;
    assign mem_data_o = pins_q.dout;
    assign mem_data_oe_o = pins_q.dout_oe;
endmodule

`default_nettype wire

// ### logic/smic_pkg.sv
/*
 * smic_pkg: constants, types and register map of the synchronous memory
 * interface controller.
 * assumes: included before every other design file of the block.
 */
package smic_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned SMIC_AW = 20;
    localparam int unsigned SMIC_DW = 32;
    localparam int unsigned SMIC_RAW = 8;
    localparam int unsigned SMIC_SPACES = 4;
    localparam int unsigned SMIC_WORDS = 4;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SMIC_OFS_SEC_BASE = 8'h00;
    localparam logic [7:0] SMIC_OFS_ADDR = 8'h10;
    localparam logic [7:0] SMIC_OFS_CMD = 8'h14;
    localparam logic [7:0] SMIC_OFS_STATUS = 8'h18;
    localparam logic [7:0] SMIC_OFS_WDAT_BASE = 8'h20;
    localparam logic [7:0] SMIC_OFS_RDAT_BASE = 8'h30;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned SEC_RL_LSB = 0;
    localparam int unsigned SEC_WL_LSB = 2;
    localparam int unsigned SEC_CHIP_ENABLE_EXTEND_BIT = 4;
    localparam int unsigned SEC_RDEN_BIT = 5;
    localparam int unsigned SEC_CLKSEL_BIT = 6;
    localparam int unsigned CMD_WRITE_BIT = 0;
    localparam int unsigned CMD_SPACE_LSB = 1;
    localparam int unsigned CMD_LEN_LSB = 3;
    localparam int unsigned STAT_BUSY_BIT = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic sync_clock_select;
        logic strobe_as_read_enable;
        logic chip_enable_extend;
        logic [1:0] sync_write_latency;
        logic [1:0] sync_read_latency;
    } smic_sec_t;

    typedef struct packed {
        smic_sec_t sec;
        logic write;
        logic [1:0] space;
        logic [1:0] len_m1;
        logic [SMIC_AW-1:0] addr;
    } smic_cmd_t;

    typedef struct packed {
        logic [SMIC_SPACES-1:0] space_chip_enable_n;
        logic sync_addr_strobe_or_read_enable;
        logic sync_output_enable_n;
        logic sync_write_enable_n;
        logic [SMIC_AW-1:0] addr;
        logic [SMIC_DW-1:0] dout;
        logic dout_oe;
    } smic_pins_t;

    typedef enum logic [2:0] {
        LS_IDLE = 3'b000,
        LS_CMD = 3'b001,
        LS_DRAIN = 3'b010,
        LS_DONE = 3'b011
    } smic_lstate_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam smic_sec_t SMIC_SEC_RST = '0;
    localparam smic_pins_t SMIC_PINS_RST = '{
        space_chip_enable_n: '1,
        sync_addr_strobe_or_read_enable: 1'b1,
        sync_output_enable_n: 1'b1,
        sync_write_enable_n: 1'b1,
        addr: '0,
        dout: '0,
        dout_oe: 1'b0
    };

endpackage

// ### logic/smic_sync.sv
/*
 * smic_sync: four-flop level synchroniser; the output changes once the
 * second and third stages agree.
 * assumes: input is a level from another clock domain.
 */
`timescale 1ns/1ns
`default_nettype none

module smic_sync
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic q_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            q_q <= 1'b0;
        end
        else
        begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
            begin
                q_q <= s3_q;
            end
        end
    end

    assign q_o = q_q;
endmodule

`default_nettype wire

// ### test/smic_top_assertions.sv
/* smic_top_assertions: concurrent checks on the ports of smic_top.
   assumes: bound into smic_top; link_clk_i runs whenever reset_n_i is high. */
`timescale 1ns/1ns
`default_nettype none
module smic_top_assertions
    import smic_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [smic_pkg::SMIC_RAW-1:0] reg_addr_i,
    input wire logic [smic_pkg::SMIC_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [smic_pkg::SMIC_DW-1:0] reg_rdata_o,
    input wire logic link_clk_i,
    input wire logic ext_clock_out_one_o,
    input wire logic ext_clock_out_two_o,
    input wire logic [smic_pkg::SMIC_SPACES-1:0] space_chip_enable_n_o,
    input wire logic shared_read_strobe_pin_o,
    input wire logic shared_output_enable_pin_o,
    input wire logic shared_write_strobe_pin_o,
    input wire logic mem_data_oe_o
);
    // ----------------------------------------
    // link-side helpers; register-port and link-side checks
    // ----------------------------------------
    logic [3:0] up_q;
    logic [3:0] wait_q;
    logic ok;
    logic ce_any;
    logic wcmd;
    assign ok = up_q == 4'hf;
    assign ce_any = ~&space_chip_enable_n_o;
    assign wcmd = ce_any & ~shared_write_strobe_pin_o;
    // ok waits out the link-side reset copy
    always_ff @(posedge link_clk_i)
    begin
        up_q <= !reset_n_i ? 4'h0 : up_q + {3'h0, !ok};
        wait_q <= !reset_n_i ? 4'hf : wcmd ? 4'h0 : wait_q + {3'h0, wait_q != 4'hf};
    end
    sequence s_sec_write;
        reg_wr_i && reg_addr_i[7:4] == 4'h0 && reg_addr_i[1:0] == 2'b00;
    endsequence
    sequence s_readback;
        reg_rd_i && reg_addr_i == $past(reg_addr_i);
    endsequence
    sequence s_deselect;
        !shared_read_strobe_pin_o && !ce_any;
    endsequence
    a_sec_readback: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s_sec_write ##1 s_readback |=> reg_rdata_o[6:0] == 7'($past(reg_wdata_i, 2)))
        else $error("space control word did not read back");
    a_clk_one_copy: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        ext_clock_out_one_o == link_clk_i) else $error("first output clock differs");
    a_clk_two_div: assert property (@(posedge link_clk_i) disable iff (!ok)
        ext_clock_out_two_o != $past(ext_clock_out_two_o)) else $error("second clock stuck");
    a_roles_apart: assert property (@(posedge link_clk_i) disable iff (!ok)
        !(!shared_output_enable_pin_o && !shared_write_strobe_pin_o))
        else $error("output and write enable both low");
    a_one_space: assert property (@(posedge link_clk_i) disable iff (!ok)
        $onehot0(~space_chip_enable_n_o)) else $error("two chip enables low");
    a_we_space: assert property (@(posedge link_clk_i) disable iff (!ok)
        !shared_write_strobe_pin_o |-> ce_any) else $error("write enable without space");
    a_drive_dir: assert property (@(posedge link_clk_i) disable iff (!ok)
        mem_data_oe_o |-> shared_output_enable_pin_o) else $error("data driven during read");
    a_wdata_late: assert property (@(posedge link_clk_i) disable iff (!ok)
        mem_data_oe_o |-> wcmd || wait_q <= 4'd7) else $error("write data too late");
    a_ce_active: assert property (@(posedge link_clk_i) disable iff (!ok)
        ce_any |-> !shared_read_strobe_pin_o || !shared_output_enable_pin_o
        || !shared_write_strobe_pin_o) else $error("chip enable held idle");
    a_deselect_one: assert property (@(posedge link_clk_i) disable iff (!ok)
        s_deselect |-> ##[1:2] shared_read_strobe_pin_o) else $error("deselect too long");
endmodule
bind smic_top smic_top_assertions u_chk (.ref_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_clk_i, .ext_clock_out_one_o,
    .ext_clock_out_two_o, .space_chip_enable_n_o, .shared_read_strobe_pin_o,
    .shared_output_enable_pin_o, .shared_write_strobe_pin_o, .mem_data_oe_o);
`default_nettype wire

// ### test/smic_mem_model.sv
/* smic_mem_model: sixteen-word synchronous memory with programmable latency.
   assumes: pins sampled on link edges that are steps of the chosen clock. */
`timescale 1ns/1ns
`default_nettype none
module smic_mem_model
    import smic_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic sel_i,
    input wire logic two_i,
    input wire logic [1:0] rl_i,
    input wire logic [1:0] wl_i,
    input wire logic [smic_pkg::SMIC_SPACES-1:0] ce_n_i,
    input wire logic strobe_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic [smic_pkg::SMIC_AW-1:0] addr_i,
    input wire logic [smic_pkg::SMIC_DW-1:0] data_i,
    input wire logic data_oe_i,
    output logic [smic_pkg::SMIC_DW-1:0] data_o
);
    logic [SMIC_DW-1:0] mem [16];
    logic [4:0] rh [3];
    logic [3:0] wh [3];
    logic [4:0] cur_rd;
    logic [4:0] pick;
    logic [3:0] wa;
    logic [7:0] cnt;
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = 32'h5a00_0000 | 32'(i);
        cnt = 8'h00;
        rh = '{default: 5'h00};
        wh = '{default: 4'h0};
    end
    // a read command is an address strobe with output enable on a selected space
    assign cur_rd = {~&ce_n_i & ~strobe_n_i & ~oe_n_i & we_n_i, addr_i[3:0]};
    assign pick = (rl_i == 2'd0) ? cur_rd : rh[rl_i - 2'd1];
    // idle bus shows a pattern that moves every step, never a held value
    assign data_o = pick[4] ? mem[pick[3:0]] : {4{cnt}};
    assign wa = (wl_i == 2'd0) ? addr_i[3:0] : wh[wl_i - 2'd1];
    always @(posedge link_clk_i)
    begin
        if (!sel_i || !two_i)
        begin
            cnt <= cnt + 8'h1b;
            rh[0] <= cur_rd;
            rh[1] <= rh[0];
            rh[2] <= rh[1];
            wh[0] <= addr_i[3:0];
            wh[1] <= wh[0];
            wh[2] <= wh[1];
            if (data_oe_i)
                mem[wa] <= data_i;
        end
    end
endmodule
`default_nettype wire

// ### test/smic_top_test.sv
/* smic_top_test: random bursts over every latency and mode, read back and compared.
   assumes: smic_top, smic_mem_model and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module smic_top_test;
    import smic_pkg::*;
    logic ref_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [SMIC_RAW-1:0] reg_addr_i = '0;
    logic [SMIC_DW-1:0] reg_wdata_i = '0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [SMIC_DW-1:0] reg_rdata_o, mem_data_o, mem_data_i, model_data;
    logic [SMIC_AW-1:0] mem_addr_o;
    logic [SMIC_SPACES-1:0] ce_n;
    logic clk_one, clk_two, strb_n, oe_n, we_n, mem_data_oe_o;
    logic live, bad_clk, bad_ce, saw_des, saw_we, saw_oe;
    logic [27:0] pins_q;
    logic [1:0] sp;
    smic_sec_t cfg [SMIC_SPACES];
    smic_sec_t cur;
    logic [SMIC_DW-1:0] ref_mem [16];
    int fail_count = 0;
    int tests_run = 0;
    int seed = 9547;
    int cycles = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    initial
    begin
        #13;
        forever #32 link_clk_i = ~link_clk_i;
    end
    // the data wire resolves to whichever side drives it
    assign mem_data_i = mem_data_oe_o ? mem_data_o : model_data;
    smic_top uut (.ref_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .link_clk_i, .ext_clock_out_one_o(clk_one), .ext_clock_out_two_o(clk_two),
        .space_chip_enable_n_o(ce_n), .shared_read_strobe_pin_o(strb_n),
        .shared_output_enable_pin_o(oe_n), .shared_write_strobe_pin_o(we_n), .mem_addr_o,
        .mem_data_i, .mem_data_o, .mem_data_oe_o);
    smic_mem_model u_mem (.link_clk_i, .sel_i(cur.sync_clock_select), .two_i(clk_two),
        .rl_i(cur.sync_read_latency), .wl_i(cur.sync_write_latency), .ce_n_i(ce_n),
        .strobe_n_i(strb_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(mem_addr_o),
        .data_i(mem_data_o), .data_oe_i(mem_data_oe_o), .data_o(model_data));
    // pins seen at each falling link edge; a change needs a rising chosen clock
    always @(negedge link_clk_i)
    begin
        if (live)
        begin
            if (cur.sync_clock_select && !clk_two && pins_q != {ce_n, strb_n, oe_n, we_n,
                mem_data_oe_o, mem_addr_o[19:0]} ) bad_clk <= 1'b1;
            if (cur.chip_enable_extend ? (!oe_n && ce_n[sp]) : (!ce_n[sp] && strb_n && we_n))
                bad_ce <= 1'b1;
            if (!strb_n && &ce_n) saw_des <= 1'b1;
            if (!we_n) saw_we <= 1'b1;
            if (!oe_n) saw_oe <= 1'b1;
        end
        pins_q <= {ce_n, strb_n, oe_n, we_n, mem_data_oe_o, mem_addr_o[19:0]};
    end
    task automatic summarize();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            summarize();
        end
    end
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        d = reg_rdata_o;
        @(posedge ref_clk_i);
    endtask
    task automatic xfer(input logic [1:0] s, input logic w, input logic [1:0] n,
        input logic [3:0] a);
        logic [31:0] d;
        int k;
        sp = s;
        cur = cfg[s];
        for (k = 0; k <= int'(n); k++)
        begin
            d = $random(seed);
            if (w)
            begin
                reg_write(SMIC_OFS_WDAT_BASE + 8'(4 * k), d);
                ref_mem[int'(a) + k] = d;
                @(posedge ref_clk_i);
            end
        end
        reg_write(SMIC_OFS_ADDR, {28'h0, a});
        @(posedge ref_clk_i);
        {saw_des, saw_we, saw_oe, bad_clk, bad_ce} = '0;
        live = 1'b1;
        reg_write(SMIC_OFS_CMD, {27'h0, n, s, w});
        k = 0;
        do
        begin
            reg_read(SMIC_OFS_STATUS, d);
            k++;
        end
        while (d[0] !== 1'b0 && k < 100);
        repeat (4) @(posedge ref_clk_i);
        live = 1'b0;
        cmp_bit(d[0], 1'b0);
        cmp_bit(bad_clk, 1'b0);
        cmp_bit(bad_ce, 1'b0);
        cmp_bit(saw_des, ~cur.strobe_as_read_enable);
        cmp_bit(saw_we, w);
        cmp_bit(saw_oe, ~w);
        for (k = 0; k <= int'(n) && !w; k++)
        begin
            reg_read(SMIC_OFS_RDAT_BASE + 8'(4 * k), d);
            cmp_word(d, ref_mem[int'(a) + k]);
        end
    endtask
    initial
    begin
        logic [31:0] d;
        logic [6:0] c;
        logic [3:0] j;
        logic [1:0] s;
        logic [1:0] n;
        for (int i = 0; i < 16; i++)
            ref_mem[i] = 32'h5a00_0000 | 32'(i);
        {live, bad_clk, bad_ce, saw_des, saw_we, saw_oe} = '0;
        cur = '0;
        sp = 2'd0;
        repeat (5) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        for (int i = 0; i < 5; i++)
        begin
            reg_read(i < 4 ? SMIC_OFS_SEC_BASE + 8'(4 * i) : 8'hfc, d);
            cmp_word(d, 32'h0);
        end
        for (int i = 0; i < 28; i++)
        begin
            j = 4'(i);
            s = 2'($random(seed));
            c = i < 16 ? {j[0] ^ j[3], j[1], j[2], j[3:2], j[1:0]} : 7'($random(seed));
            n = i == 0 ? 2'd3 : 2'($random(seed));
            cfg[s] = c;
            reg_write(SMIC_OFS_SEC_BASE + {4'h0, s, 2'b00}, {25'h0, c});
            reg_read(SMIC_OFS_SEC_BASE + {4'h0, s, 2'b00}, d);
            cmp_word(d & 32'h7f, {25'h0, c});
            j = {2'($random(seed)), 2'b00};
            xfer(s, 1'b1, n, j);
            xfer(s, 1'b0, n, j);
        end
        summarize();
    end
endmodule
`default_nettype wire
